// ==== hw/port_pin_regs.svh ====
// port widths, reset values and field positions for the port pin block
// assumes inclusion by the port pin package and modules only
`ifndef PORT_PIN_REGS_SVH
`define PORT_PIN_REGS_SVH
`define P0_W 4
`define P1_W 2
`define P2_W 3
`define P4_W 4
`define P6_W 2
`define P8_W 6
`define P0_DIR_RST 4'hf
`define P1_DIR_RST 2'h3
`define P2_DIR_RST 3'h7
`define P4_DIR_RST 4'hf
`define P6_DIR_RST 2'h3
`define P8_DIR_RST 6'h00
`define P8_DATA_RST 6'h00
`define PU_SH_P0_BIT 0
`define PU_SH_P1_BIT 1
`define PU_SH_P4_BIT 4
`define SEG_W 24
`define COM_W 4
`define SEG_P8_LO 17
`define P2_SCK_BIT 0
`define P2_SO_BIT 1
`define P2_SI_BIT 2
`define P6_TMR_BIT 0
`define P6_INT_BIT 1
`endif

// ==== hw/port_pin_pkg.sv ====
// types for the port pin block
// assumes constants come from port_pin_regs.svh
package port_pin_pkg;
	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_mode_t;
endpackage : port_pin_pkg

// ==== hw/edge_detect.sv ====
// edge detector for the external interrupt pin
// assumes the pin level is already synchronous to clk_in
`timescale 1ns/1ps
module edge_detect (
	input wire logic clk_in, // system clock
	input wire logic sys_rst_in, // sync reset, active high
	input wire logic level_in, // sampled pin level
	input wire port_pin_pkg::edge_mode_t mode_in, // valid edge select
	output logic pulse_out // one-cycle detection
);
	logic prev_q;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pulse_out <= 1'b0;
		end else begin
			case (mode_in)
				port_pin_pkg::EDGE_RISE: pulse_out <= level_in & ~prev_q;
				port_pin_pkg::EDGE_FALL: pulse_out <= ~level_in & prev_q;
				port_pin_pkg::EDGE_BOTH: pulse_out <= level_in ^ prev_q;
				default: pulse_out <= 1'b0;
			endcase
		end
	end
endmodule : edge_detect

// ==== hw/port_pin_mux_block.sv ====
// general-purpose port pins with direction, pull-up and alternate-function muxing
// assumes pin inputs are synchronous to clk_in; control bits come straight from ports
// direction bit set means input, matching the reset-to-input default of every port except port eight
`timescale 1ns/1ps
`include "port_pin_regs.svh"
module port_pin_mux_block (
	input wire logic clk_in, // system clock
	input wire logic sys_rst_in, // sync reset, active high
	// software side: direction (1 = input), data latches, options
	input wire logic [`P0_W-1:0] p0_dir_in, // port zero direction
	input wire logic [`P0_W-1:0] p0_data_in, // port zero latch data
	input wire logic [`P1_W-1:0] p1_dir_in, // port one direction
	input wire logic [`P1_W-1:0] p1_data_in, // port one latch data
	input wire logic [`P2_W-1:0] p2_dir_in, // port two direction
	input wire logic [`P2_W-1:0] p2_data_in, // port two latch data
	input wire logic [`P4_W-1:0] p4_dir_in, // port four direction
	input wire logic [`P4_W-1:0] p4_data_in, // port four latch data
	input wire logic [`P6_W-1:0] p6_dir_in, // port six direction
	input wire logic [`P6_W-1:0] p6_data_in, // port six latch data
	input wire logic [`P8_W-1:0] p8_dir_in, // port eight direction
	input wire logic [`P8_W-1:0] p8_data_in, // port eight latch data
	input wire logic ctl_we_in, // load all direction and data inputs
	input wire logic [7:0] pullup_opt_shared_in, // shared whole-port pull-up option
	input wire logic [`P2_W-1:0] pullup_opt_port2_bitwise_in, // port two per-bit pull-up
	input wire logic keyret_mode_reg_in, // key-return mode on port four
	input wire logic ser_en_in, // serial function owns port two
	input wire logic tmr_en_in, // timer output owns port six bit zero
	input wire logic lcd_seg_p8_en_in, // segment function owns port eight
	input wire port_pin_pkg::edge_mode_t int_edge_in, // interrupt edge select
	// peripheral side
	input wire logic ser_clk_o_in, // serial clock from serial unit
	input wire logic ser_clk_oe_in, // serial unit drives its clock
	input wire logic ser_dout_in, // serial data from serial unit
	input wire logic timer_b_in, // second eight-bit timer output
	input wire logic [`SEG_W-1:0] lcd_seg_in, // segment levels from lcd unit
	input wire logic [`COM_W-1:0] lcd_com_in, // common levels from lcd unit
	input wire logic lcd_run_in, // lcd unit enabled
	// pin side
	input wire logic [`P0_W-1:0] port_zero_bits_in, // port zero pin levels
	input wire logic [`P1_W-1:0] p1_pin_in, // port one pin levels
	input wire logic [`P2_W-1:0] p2_pin_in, // port two pin levels
	input wire logic [`P4_W-1:0] p4_pin_in, // port four pin levels
	input wire logic [`P6_W-1:0] p6_pin_in, // port six pin levels
	input wire logic [`P8_W-1:0] port_eight_bits_in, // port eight pin levels
	output logic [`P0_W-1:0] port_zero_bits_out, // port zero drive
	output logic [`P0_W-1:0] port_zero_bits_oe_out, // port zero enable
	output logic [`P1_W-1:0] p1_pin_out, // port one drive
	output logic [`P1_W-1:0] p1_pin_oe_out, // port one enable
	output logic [`P2_W-1:0] p2_pin_out, // port two drive
	output logic [`P2_W-1:0] p2_pin_oe_out, // port two enable
	output logic [`P4_W-1:0] p4_pin_out, // port four drive
	output logic [`P4_W-1:0] p4_pin_oe_out, // port four enable
	output logic [`P6_W-1:0] p6_pin_out, // port six drive
	output logic [`P6_W-1:0] p6_pin_oe_out, // port six enable
	output logic [`P8_W-1:0] port_eight_bits_out, // port eight drive
	output logic [`P8_W-1:0] port_eight_bits_oe_out, // port eight enable
	output logic [`P0_W-1:0] p0_pu_out, // port zero pull-up on
	output logic [`P1_W-1:0] p1_pu_out, // port one pull-up on
	output logic [`P2_W-1:0] p2_pu_out, // port two pull-up on
	output logic [`P4_W-1:0] p4_pu_out, // port four pull-up on
	output logic [`SEG_W-1:0] lcd_segment_outs, // segment pins
	output logic [`COM_W-1:0] lcd_common_outs, // common pins
	// read-back and peripheral inputs
	output logic [`P0_W-1:0] p0_read_out, // port zero read value
	output logic [`P1_W-1:0] p1_read_out, // port one read value
	output logic [`P2_W-1:0] p2_read_out, // port two read value
	output logic [`P4_W-1:0] p4_read_out, // port four read value
	output logic [`P6_W-1:0] p6_read_out, // port six read value
	output logic [`P8_W-1:0] p8_read_out, // port eight read value
	output logic ser_clk_pin_out, // serial clock seen at pin
	output logic ser_din_pin_out, // serial data in seen at pin
	output logic [`P4_W-1:0] keyret_inputs_out, // key-return levels
	output logic int_pulse_out // valid interrupt edge, one cycle
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// read value: latch for outputs, pin for inputs
	// eight bits wide so one function serves every port; callers cut the result
	function automatic logic [7:0] rd_mux(input logic [7:0] dir, input logic [7:0] lat,
		input logic [7:0] pin);
		rd_mux = (dir & pin) | (~dir & lat);
	endfunction : rd_mux

	// ---------------------------------------------------------------
	// direction and data latches
	// ---------------------------------------------------------------
	logic [`P0_W-1:0] p0_dir_q, p0_lat_q;
	logic [`P1_W-1:0] p1_dir_q, p1_lat_q;
	logic [`P2_W-1:0] p2_dir_q, p2_lat_q;
	logic [`P4_W-1:0] p4_dir_q, p4_lat_q;
	logic [`P6_W-1:0] p6_dir_q, p6_lat_q;
	logic [`P8_W-1:0] p8_dir_q, p8_lat_q;

	// every port resets to input except port eight, which leaves reset driving low;
	// the write strobe is a level, so it reloads on every cycle it stays high
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			p0_dir_q <= `P0_DIR_RST;
			p1_dir_q <= `P1_DIR_RST;
			p2_dir_q <= `P2_DIR_RST;
			p4_dir_q <= `P4_DIR_RST;
			p6_dir_q <= `P6_DIR_RST;
			p8_dir_q <= `P8_DIR_RST;
		end else if (ctl_we_in) begin
			p0_dir_q <= p0_dir_in;
			p1_dir_q <= p1_dir_in;
			p2_dir_q <= p2_dir_in;
			p4_dir_q <= p4_dir_in;
			p6_dir_q <= p6_dir_in;
			p8_dir_q <= p8_dir_in;
		end
	end

	// latches reset low so turning a bit to output never drives a value
	// picked up before reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			p0_lat_q <= 4'h0;
			p1_lat_q <= 2'h0;
			p2_lat_q <= 3'h0;
			p4_lat_q <= 4'h0;
			p6_lat_q <= 2'h0;
			p8_lat_q <= `P8_DATA_RST;
		end else if (ctl_we_in) begin
			p0_lat_q <= p0_data_in;
			p1_lat_q <= p1_data_in;
			p2_lat_q <= p2_data_in;
			p4_lat_q <= p4_data_in;
			p6_lat_q <= p6_data_in;
			p8_lat_q <= p8_data_in;
		end
	end

	// ---------------------------------------------------------------
	// next pin drive with alternate functions
	// ---------------------------------------------------------------
	logic [`P2_W-1:0] p2_d, p2_oe_d;
	logic [`P6_W-1:0] p6_d;
	logic [`P8_W-1:0] p8_d, seg_rev;

	// serial unit owns port two only while enabled; data in on bit two is an
	// input path only, so that bit keeps its latch and its direction bit
	always_comb begin
		p2_d = p2_lat_q;
		p2_oe_d = ~p2_dir_q;
		if (ser_en_in) begin
			p2_d[`P2_SCK_BIT] = ser_clk_o_in;
			// clock drives only when the serial unit masters it and direction allows
			p2_oe_d[`P2_SCK_BIT] = ~p2_dir_q[`P2_SCK_BIT] & ser_clk_oe_in;
			p2_d[`P2_SO_BIT] = ser_dout_in;
		end
	end

	// timer output replaces the latch on bit zero; bit one stays a plain bit
	// whose level also feeds the interrupt edge detector
	always_comb begin
		p6_d = p6_lat_q;
		if (tmr_en_in) begin
			p6_d[`P6_TMR_BIT] = timer_b_in;
		end
	end

	// segment 22 lands on bit zero and segment 17 on bit five; direction still
	// gates the drive, so software must keep port eight as output for segments
	always_comb begin
		for (int i = 0; i < `P8_W; i++) begin
			seg_rev[i] = lcd_seg_in[`SEG_P8_LO + `P8_W - 1 - i];
		end
		p8_d = lcd_seg_p8_en_in ? seg_rev : p8_lat_q;
	end

	// ---------------------------------------------------------------
	// registered pin outputs
	// ---------------------------------------------------------------
	// every pin leaves through a flop: one cycle of latency, but no glitch on a
	// pin when an alternate-function enable toggles
	// port eight enable follows its direction even while segments own the data
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			port_zero_bits_out <= 4'h0;
			port_zero_bits_oe_out <= 4'h0;
			p1_pin_out <= 2'h0;
			p1_pin_oe_out <= 2'h0;
			p2_pin_out <= 3'h0;
			p2_pin_oe_out <= 3'h0;
			p4_pin_out <= 4'h0;
			p4_pin_oe_out <= 4'h0;
			p6_pin_out <= 2'h0;
			p6_pin_oe_out <= 2'h0;
			port_eight_bits_out <= 6'h00;
			port_eight_bits_oe_out <= 6'h3f;
		end else begin
			port_zero_bits_out <= p0_lat_q;
			port_zero_bits_oe_out <= ~p0_dir_q;
			p1_pin_out <= p1_lat_q;
			p1_pin_oe_out <= ~p1_dir_q;
			p2_pin_out <= p2_d;
			p2_pin_oe_out <= p2_oe_d;
			p4_pin_out <= p4_lat_q;
			p4_pin_oe_out <= ~p4_dir_q;
			p6_pin_out <= p6_d;
			p6_pin_oe_out <= ~p6_dir_q;
			port_eight_bits_out <= p8_d;
			port_eight_bits_oe_out <= ~p8_dir_q;
		end
	end

	// ---------------------------------------------------------------
	// pull-ups: only ever on input bits
	// ---------------------------------------------------------------
	// a pull-up against an active driver only wastes current, so every mask
	// is anded with the direction bits
	// port four takes either the shared option bit or key-return mode
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			p0_pu_out <= 4'h0;
			p1_pu_out <= 2'h0;
			p2_pu_out <= 3'h0;
			p4_pu_out <= 4'h0;
		end else begin
			p0_pu_out <= p0_dir_q & {`P0_W{pullup_opt_shared_in[`PU_SH_P0_BIT]}};
			p1_pu_out <= p1_dir_q & {`P1_W{pullup_opt_shared_in[`PU_SH_P1_BIT]}};
			p2_pu_out <= p2_dir_q & pullup_opt_port2_bitwise_in;
			p4_pu_out <= p4_dir_q & {`P4_W{pullup_opt_shared_in[`PU_SH_P4_BIT]
				| keyret_mode_reg_in}};
		end
	end

	// ---------------------------------------------------------------
	// lcd pins: low until the lcd unit runs
	// ---------------------------------------------------------------
	// levels reach the segment and common pins only while the lcd unit runs, so a stopped
	// unit never leaves those at a stale level; segments shared onto port eight ignore lcd_run_in
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			lcd_segment_outs <= 24'h000000;
			lcd_common_outs <= 4'h0;
		end else begin
			lcd_segment_outs <= lcd_run_in ? lcd_seg_in : 24'h000000;
			lcd_common_outs <= lcd_run_in ? lcd_com_in : 4'h0;
		end
	end

	// ---------------------------------------------------------------
	// read-back and peripheral input paths
	// ---------------------------------------------------------------
	// an output bit reads back its latch, not its pin, so a loaded pin cannot
	// corrupt a read-modify-write of the port
	// the serial clock pin is passed on ungated so an outside master can still
	// clock the serial unit; serial data in is held low while the unit is off
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			p0_read_out <= 4'h0;
			p1_read_out <= 2'h0;
			p2_read_out <= 3'h0;
			p4_read_out <= 4'h0;
			p6_read_out <= 2'h0;
			p8_read_out <= 6'h00;
			ser_clk_pin_out <= 1'b0;
			ser_din_pin_out <= 1'b0;
			keyret_inputs_out <= 4'h0;
		end else begin
			p0_read_out <= 4'(rd_mux(8'(p0_dir_q), 8'(p0_lat_q), 8'(port_zero_bits_in)));
			p1_read_out <= 2'(rd_mux(8'(p1_dir_q), 8'(p1_lat_q), 8'(p1_pin_in)));
			p2_read_out <= 3'(rd_mux(8'(p2_dir_q), 8'(p2_lat_q), 8'(p2_pin_in)));
			p4_read_out <= 4'(rd_mux(8'(p4_dir_q), 8'(p4_lat_q), 8'(p4_pin_in)));
			p6_read_out <= 2'(rd_mux(8'(p6_dir_q), 8'(p6_lat_q), 8'(p6_pin_in)));
			p8_read_out <= 6'(rd_mux(8'(p8_dir_q), 8'(p8_lat_q), 8'(port_eight_bits_in)));
			ser_clk_pin_out <= p2_pin_in[`P2_SCK_BIT];
			ser_din_pin_out <= ser_en_in & p2_pin_in[`P2_SI_BIT];
			keyret_inputs_out <= p4_dir_q & p4_pin_in;
		end
	end

	// ---------------------------------------------------------------
	// external interrupt
	// ---------------------------------------------------------------
	// the pin is already synchronous, so the detector adds no extra stages;
	// edge select none keeps the pulse low whatever the pin does
	edge_detect u_int_edge (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.level_in(p6_pin_in[`P6_INT_BIT]),
		.mode_in(int_edge_in),
		.pulse_out(int_pulse_out)
	);
endmodule : port_pin_mux_block

// ==== dv/pin_board_model.sv ====
// board side of the port pins: drivers, external sources and floating lines
// assumes one model per port, levels fed back to the block's pin inputs
`timescale 1ns/1ps
module pin_board_model #(parameter int W = 4) (
	input logic clk_in, // system clock
	input logic [W-1:0] drv_in, oe_in, pu_in, ext_in, ext_en_in, // block and board sources
	output logic [W-1:0] lvl_out // resolved pin level
);
	logic [W-1:0] last_q = '0;
	// a released line without pull-up flips every cycle so a stale value never looks valid
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe_in[i]) lvl_out[i] = drv_in[i];
			else if (ext_en_in[i]) lvl_out[i] = ext_in[i];
			else lvl_out[i] = pu_in[i] | ~last_q[i];
		end
	end
	always_ff @(posedge clk_in) last_q <= lvl_out;
endmodule : pin_board_model

// ==== dv/port_pin_mux_block_assertions.sv ====
// assertions tying the port pin outputs to the control inputs
// assumes binding to port_pin_mux_block; all checks but the reset and no-edge ones wait for three quiet cycles
`timescale 1ns/1ps
module port_pin_checker (
	input logic clk_in, sys_rst_in, ctl_we_in, keyret_mode_reg_in, ser_en_in, tmr_en_in,
	input logic lcd_seg_p8_en_in, ser_dout_in, timer_b_in, lcd_run_in, int_pulse_out,
	input logic [3:0] p0_dir_in, p0_data_in, p4_dir_in, port_zero_bits_out,
	input logic [3:0] port_zero_bits_oe_out, p0_pu_out, p4_pu_out, lcd_common_outs,
	input logic [2:0] p2_dir_in, pullup_opt_port2_bitwise_in, p2_pin_out, p2_pu_out,
	input logic [1:0] p6_dir_in, p6_pin_out, p6_pin_oe_out,
	input logic [5:0] port_eight_bits_out, port_eight_bits_oe_out,
	input logic [7:0] pullup_opt_shared_in,
	input logic [23:0] lcd_seg_in,
	input port_pin_pkg::edge_mode_t int_edge_in
);
	logic [58:0] cur, prev_q;
	logic [1:0] quiet_q;
	logic ok;
	// ----------------------------------------
	// settle window: latency is two edges, so wait for three quiet ones
	// ----------------------------------------
	assign cur = {p0_dir_in, p0_data_in, p2_dir_in, p4_dir_in, p6_dir_in, pullup_opt_shared_in,
		pullup_opt_port2_bitwise_in, keyret_mode_reg_in, ser_en_in, tmr_en_in,
		lcd_seg_p8_en_in, ser_dout_in, timer_b_in, lcd_seg_in, lcd_run_in};
	assign ok = quiet_q == 2'h3 && cur == prev_q;
	always_ff @(posedge clk_in) begin
		prev_q <= cur;
		if (sys_rst_in || !ctl_we_in || cur != prev_q) quiet_q <= 2'h0;
		else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_p0_oe; ok |-> port_zero_bits_oe_out == ~p0_dir_in; endproperty
	a_p0_oe: assert property (p_p0_oe) else $error("port zero enable wrong");
	property p_p0_drv;
		ok |-> (port_zero_bits_out & ~p0_dir_in) == (p0_data_in & ~p0_dir_in);
	endproperty
	a_p0_drv: assert property (p_p0_drv) else $error("port zero drive wrong");
	property p_p0_pu; ok |-> p0_pu_out == ({4{pullup_opt_shared_in[0]}} & p0_dir_in); endproperty
	a_p0_pu: assert property (p_p0_pu) else $error("port zero pull-up wrong");
	property p_p2_pu; ok |-> p2_pu_out == (pullup_opt_port2_bitwise_in & p2_dir_in); endproperty
	a_p2_pu: assert property (p_p2_pu) else $error("port two pull-up wrong");
	property p_p4_pu;
		ok |-> p4_pu_out == ({4{pullup_opt_shared_in[4] | keyret_mode_reg_in}} & p4_dir_in);
	endproperty
	a_p4_pu: assert property (p_p4_pu) else $error("port four pull-up wrong");
	property p_seg; ok && lcd_seg_p8_en_in && lcd_run_in |->
		port_eight_bits_out[0] == lcd_seg_in[22] && port_eight_bits_out[5] == lcd_seg_in[17]; endproperty
	a_seg: assert property (p_seg) else $error("segment share order wrong");
	property p_tmr;
		ok && tmr_en_in && !p6_dir_in[0] |-> p6_pin_oe_out[0] && p6_pin_out[0] == timer_b_in;
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer output not on pin");
	property p_sdo; ok && ser_en_in && !p2_dir_in[1] |-> p2_pin_out[1] == ser_dout_in; endproperty
	a_sdo: assert property (p_sdo) else $error("serial data out not on pin");
	property p_rst; $fell(sys_rst_in) |-> port_eight_bits_oe_out == 6'h3f &&
		port_eight_bits_out == 6'h00 && lcd_common_outs == 4'h0 && port_zero_bits_oe_out == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset pin state wrong");
	property p_int_none; (int_edge_in == port_pin_pkg::EDGE_NONE) [*4] |-> !int_pulse_out; endproperty
	a_int_none: assert property (p_int_none) else $error("interrupt with no edge selected");
endmodule : port_pin_checker

// ==== dv/testbench.sv ====
// self-checking bench for the port pin block with a board model on four ports
// assumes the bench drives the port one and port eight pin levels itself
`timescale 1ns/1ps
module testbench;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, ctl_we_in = 1'b0, keyret_mode_reg_in = 1'b0;
	logic ser_en_in = 1'b0, tmr_en_in = 1'b0, lcd_seg_p8_en_in = 1'b0, ser_clk_o_in = 1'b0;
	logic ser_clk_oe_in = 1'b0, ser_dout_in = 1'b0, timer_b_in = 1'b0, lcd_run_in = 1'b0;
	logic [3:0] p0_dir_in = '0, p0_data_in = '0, p4_dir_in = '0, p4_data_in = '0, lcd_com_in = '0;
	logic [3:0] x0 = '0, e0 = '0, x4 = '0, e4 = '0;
	logic [2:0] p2_dir_in = '0, p2_data_in = '0, pullup_opt_port2_bitwise_in = '0, x2 = '0, e2 = '0;
	logic [1:0] p1_dir_in = '0, p1_data_in = '0, p6_dir_in = '0, p6_data_in = '0, p1_pin_in = '0;
	logic [1:0] x6 = '0, e6 = '0;
	logic [5:0] p8_dir_in = '0, p8_data_in = '0, port_eight_bits_in = '0;
	logic [7:0] pullup_opt_shared_in = '0;
	logic [23:0] lcd_seg_in = '0;
	port_pin_pkg::edge_mode_t int_edge_in = port_pin_pkg::EDGE_NONE;
	logic [3:0] port_zero_bits_in, p4_pin_in, port_zero_bits_out, port_zero_bits_oe_out, p4_pin_out;
	logic [3:0] p4_pin_oe_out, p0_pu_out, p4_pu_out, lcd_common_outs, p0_read_out, p4_read_out;
	logic [3:0] keyret_inputs_out;
	logic [2:0] p2_pin_in, p2_pin_out, p2_pin_oe_out, p2_pu_out, p2_read_out;
	logic [1:0] p6_pin_in, p1_pin_out, p1_pin_oe_out, p6_pin_out, p6_pin_oe_out, p1_pu_out;
	logic [1:0] p1_read_out, p6_read_out;
	logic [5:0] port_eight_bits_out, port_eight_bits_oe_out, p8_read_out;
	logic [23:0] lcd_segment_outs;
	logic ser_clk_pin_out, ser_din_pin_out, int_pulse_out;
	int failures = 0, total_checks = 0;
	always #2 clk_in = ~clk_in;
	port_pin_mux_block dut_u (.*);
	pin_board_model #(.W(4)) m0 (.clk_in, .drv_in(port_zero_bits_out), .oe_in(port_zero_bits_oe_out),
		.pu_in(p0_pu_out), .ext_in(x0), .ext_en_in(e0), .lvl_out(port_zero_bits_in));
	pin_board_model #(.W(3)) m2 (.clk_in, .drv_in(p2_pin_out), .oe_in(p2_pin_oe_out),
		.pu_in(p2_pu_out), .ext_in(x2), .ext_en_in(e2), .lvl_out(p2_pin_in));
	pin_board_model #(.W(4)) m4 (.clk_in, .drv_in(p4_pin_out), .oe_in(p4_pin_oe_out),
		.pu_in(p4_pu_out), .ext_in(x4), .ext_en_in(e4), .lvl_out(p4_pin_in));
	pin_board_model #(.W(2)) m6 (.clk_in, .drv_in(p6_pin_out), .oe_in(p6_pin_oe_out),
		.pu_in(2'h0), .ext_in(x6), .ext_en_in(e6), .lvl_out(p6_pin_in));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic settle;
		repeat (4) @(negedge clk_in);
	endtask : settle
	task automatic give_verdict;
		if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		check("p8 oe", port_eight_bits_oe_out, 6'h3f);
		check("p8 out", port_eight_bits_out, 6'h00);
		check("p0 oe", port_zero_bits_oe_out, 4'h0);
		check("p1 oe", p1_pin_oe_out, 2'h0);
		check("p2 oe", p2_pin_oe_out, 3'h0);
		check("p4 oe", p4_pin_oe_out, 4'h0);
		check("p6 oe", p6_pin_oe_out, 2'h0);
		check("lcd", {lcd_segment_outs, lcd_common_outs}, 28'h0);
	endtask : t_reset
	task automatic t_port0;
		p0_dir_in = 4'h0;
		p0_data_in = 4'h5;
		settle();
		check("p0 out", {port_zero_bits_oe_out, port_zero_bits_out}, 8'hf5);
		p0_dir_in = 4'h3;
		{e0, x0} = 8'h32;
		settle();
		check("p0 read", {port_zero_bits_oe_out, p0_read_out}, 8'hc6);
	endtask : t_port0
	task automatic t_pullup;
		pullup_opt_shared_in = 8'h13;
		p4_dir_in = 4'h5;
		pullup_opt_port2_bitwise_in = 3'h5;
		p2_dir_in = 3'h3;
		settle();
		check("p0 p1 pu", {p0_pu_out, p1_pu_out}, 6'h0f);
		check("p4 pu", p4_pu_out, 4'h5);
		check("p2 pu", p2_pu_out, 3'h1);
		pullup_opt_shared_in = 8'h00;
		keyret_mode_reg_in = 1'b1;
		settle();
		check("p4 pu key", {p0_pu_out, p4_pu_out}, 8'h05);
		keyret_mode_reg_in = 1'b0;
		p4_dir_in = 4'hf;
	endtask : t_pullup
	task automatic t_alt;
		{ser_en_in, ser_clk_oe_in, ser_clk_o_in, ser_dout_in} = 4'he;
		{p2_dir_in, p2_data_in, e2, x2} = 12'h8a4;
		{tmr_en_in, timer_b_in, p6_dir_in} = 4'he;
		{e4, x4} = 8'hfa;
		settle();
		check("p2 alt", {p2_pin_oe_out, p2_pin_out[1:0]}, 5'h0d);
		check("ser in", {ser_clk_pin_out, ser_din_pin_out}, 2'h3);
		check("timer", {p6_pin_oe_out, p6_pin_out[0]}, 3'h3);
		check("keyret", {keyret_inputs_out, p4_read_out}, 8'haa);
		{ser_clk_oe_in, ser_dout_in, timer_b_in} = 3'h2;
		{e2, x2} = 6'h29;
		settle();
		check("p2 clk off", {p2_pin_oe_out, p2_pin_out[1]}, 4'h5);
		check("ser in 2", {ser_clk_pin_out, ser_din_pin_out}, 2'h2);
		check("timer low", p6_pin_out[0], 1'b0);
		{ser_en_in, tmr_en_in, x2} = 5'h05;
		settle();
		check("p2 latch", {p2_pin_out[1:0], ser_din_pin_out}, 3'h4);
	endtask : t_alt
	task automatic t_seg;
		logic [5:0] exp8;
		{lcd_seg_in, lcd_com_in, lcd_run_in, lcd_seg_p8_en_in} = 30'h2970f867;
		for (int i = 0; i < 6; i++) exp8[i] = lcd_seg_in[22 - i];
		settle();
		check("p8 seg", port_eight_bits_out, exp8);
		check("lcd on", {lcd_segment_outs, lcd_common_outs}, 28'ha5c3e19);
		lcd_run_in = 1'b0;
		settle();
		check("lcd off", {lcd_segment_outs, lcd_common_outs}, 28'h0);
		lcd_seg_p8_en_in = 1'b0;
	endtask : t_seg
	task automatic t_edge;
		int n;
		int exp_n[4] = '{0, 1, 1, 2};
		p6_dir_in = 2'h3;
		e6 = 2'h2;
		for (int m = 0; m < 4; m++) begin
			n = 0;
			int_edge_in = port_pin_pkg::edge_mode_t'(m[1:0]);
			settle();
			for (int k = 0; k < 16; k++) begin
				x6[1] = k < 8;
				@(negedge clk_in);
				if (int_pulse_out === 1'b1) n++;
			end
			check("edge pulses", n, exp_n[m]);
		end
	endtask : t_edge
	task automatic t_ports;
		{p1_dir_in, p1_data_in, p1_pin_in} = 6'h26;
		p8_dir_in = 6'h0f;
		p8_data_in = 6'h2a;
		port_eight_bits_in = 6'h05;
		p4_dir_in = 4'h3;
		p4_data_in = 4'h9;
		{e6, x6} = 4'hd;
		settle();
		check("p1", {p1_pin_oe_out, p1_pin_out, p1_read_out}, 6'h17);
		check("p8", {port_eight_bits_oe_out, port_eight_bits_out, p8_read_out}, 18'h30aa5);
		check("p4", {p4_pin_oe_out, p4_pin_out, p4_read_out, keyret_inputs_out}, 16'hc9a2);
		check("p2 p6 read", {p2_read_out, p6_read_out}, 5'h19);
	endtask : t_ports
	initial begin
		repeat (10) @(negedge clk_in);
		sys_rst_in = 1'b0;
		settle();
		t_reset();
		{p0_dir_in, p1_dir_in, p2_dir_in, p4_dir_in, p6_dir_in} = 15'h7fff;
		ctl_we_in = 1'b1;
		t_port0();
		t_pullup();
		t_alt();
		t_seg();
		t_edge();
		t_ports();
		ctl_we_in = 1'b0;
		sys_rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		sys_rst_in = 1'b0;
		settle();
		t_reset();
		give_verdict();
	end
endmodule : testbench
bind port_pin_mux_block port_pin_checker chk_u (.*);
